// File: design/commutation_pwm_counter.sv
// Timer-counter channel in pulse-width-modulation mode driving one high-side phase output
// ======================================================
// Functional notes
// - Reload loads the initial count and sets the counter running.
// - Start sets the counter running from its present value.
// - Start never reinitialises the count; only reload does.
// - First halt event stops the counter and forces the output low.
// - Each count event steps the counter by one in the programmed direction; here only on a prescaler tick while running, and it wraps or turns at period ends.
// - Switch event comes from its trigger or command bit 0.
// - Second halt event behaves exactly like the first one.
// - Mode field value 4 enables event-controlled PWM output generation.
// - Command bit 2 injects reload: initialise, run, emit pulses.
// - Command bit 3 injects the first halt: output forced to zero.
// - Source code 0 is low, 1 is high, others pick trigger inputs.
// - Match action: 0 set, 1 clear, 2 toggle, 3 keep.
// - Period sets cycle length, compare value sets duty within it.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module commutation_pwm_counter #(
    parameter int CNT_W = 32,
    parameter int N_TRIG = 254
) (
    input wire logic clock,                // 200 MHz clock
    input wire logic rst_b,                // Synchronous reset, active low
    input wire logic [7:0] addr,           // Register byte address
    input wire logic [31:0] wr_data,       // Write data
    input wire logic wr_en,                // Write strobe
    input wire logic rd_en,                // Read strobe
    output logic [31:0] rd_data,           // Read data, cycle after rd_en
    input wire logic [N_TRIG-1:0] trig_in, // Asynchronous trigger inputs
    output logic high_side_out,            // PWM line to the gate driver
    output logic counter_running           // Counter is running
);
    logic [31:0] ctrl_ff, sel0_ff, sel1_ff, edge_ff, match_ff, dt_ff;
    logic [CNT_W-1:0] cmp_ff, cmp_buf_ff, per_ff, per_buf_ff;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, init_val;
    logic [pwm_pkg::NUM_EV-1:0] cmd_ff, ev;
    logic [31:0] rd_data_ff, nxt_rd;
    logic running_ff, kill_ff, line_ff, up_ff, sw_pend_ff, out_ff;
    logic nxt_running, nxt_kill, nxt_line, nxt_up, tc, cmp_hit;
    logic pwm_mode, halt_ev, count_step, tick;
    pwm_pkg::dir_e dir;
    pwm_pkg::match_e cmp_act, tc_act;
    trig_if tif ();

    assign pwm_mode = ctrl_ff[pwm_pkg::CTRL_MODE_LSB +: 3] == pwm_pkg::MODE_PWM;
    assign dir = pwm_pkg::dir_e'(ctrl_ff[pwm_pkg::CTRL_DIR_LSB +: 2]);
    assign cmp_act = pwm_pkg::match_e'(match_ff[pwm_pkg::MATCH_CMP_LSB +: 2]);
    assign tc_act = pwm_pkg::match_e'(match_ff[pwm_pkg::MATCH_TC_LSB +: 2]);

    // ======================================================
    // Event sources
    // Selector and edge settings toward the trigger detector
    assign tif.sel[pwm_pkg::EV_SWITCH] = sel0_ff[7:0];
    assign tif.sel[pwm_pkg::EV_COUNT] = sel0_ff[15:8];
    assign tif.sel[pwm_pkg::EV_RELOAD] = sel0_ff[23:16];
    assign tif.sel[pwm_pkg::EV_HALT] = sel0_ff[31:24];
    assign tif.sel[pwm_pkg::EV_START] = sel1_ff[7:0];
    assign tif.sel[pwm_pkg::EV_HALT2] = sel1_ff[15:8];
    for (genvar i = 0; i < pwm_pkg::NUM_EV; i++) begin : g_edge
        assign tif.edge_mode[i] = edge_ff[2*i +: 2];
    end

    trig_detect #(.N_TRIG(N_TRIG)) u_trig (
        .clock(clock),
        .rst_b(rst_b),
        .trig_in(trig_in),
        .tif(tif)
    );

    prescale_tick u_pre (
        .clock(clock),
        .rst_b(rst_b),
        .clear(ev[pwm_pkg::EV_RELOAD]),
        .div_sel(dt_ff[2:0]),
        .tick(tick)
    );

    // Command bits become one-cycle pulses; they read back as zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmd_ff <= '0;
        end else if (wr_en && addr == pwm_pkg::OFS_CMD) begin
            cmd_ff <= wr_data[pwm_pkg::NUM_EV-1:0];
        end else begin
            cmd_ff <= '0;
        end
    end

    // Events only act while the channel is in PWM mode
    assign ev = pwm_mode ? (tif.ev | cmd_ff) : '0;
    assign halt_ev = ev[pwm_pkg::EV_HALT] | ev[pwm_pkg::EV_HALT2];
    assign count_step = running_ff && ev[pwm_pkg::EV_COUNT] && tick && !halt_ev && !ev[pwm_pkg::EV_RELOAD];
    assign init_val = (dir == pwm_pkg::CNT_DOWN) ? per_ff : '0;

    // ======================================================
    // Match action applied to the line
    function automatic logic apply_act(input pwm_pkg::match_e act, input logic line);
        case (act)
            pwm_pkg::ACT_SET: apply_act = 1'b1;
            pwm_pkg::ACT_CLEAR: apply_act = 1'b0;
            pwm_pkg::ACT_INVERT: apply_act = ~line;
            default: apply_act = line;
        endcase
    endfunction : apply_act

    // ======================================================
    // Counter next state
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_up = up_ff;
        tc = 1'b0;
        if (ev[pwm_pkg::EV_RELOAD] && !halt_ev) begin
            nxt_cnt = init_val;
            nxt_up = dir != pwm_pkg::CNT_DOWN;
        end else if (count_step) begin
            case (dir)
                pwm_pkg::CNT_UP: begin
                    if (cnt_ff >= per_ff) begin
                        nxt_cnt = '0;
                        tc = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                pwm_pkg::CNT_DOWN: begin
                    if (cnt_ff == '0) begin
                        nxt_cnt = per_ff;
                        tc = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                default: begin
                    // Up-down: variant 1 ends its cycle at zero, variant 2 at both turns
                    if (up_ff && cnt_ff >= per_ff) begin
                        nxt_up = 1'b0;
                        nxt_cnt = (cnt_ff == '0) ? cnt_ff : cnt_ff - 1'b1;
                        tc = dir == pwm_pkg::CNT_UPDN2;
                    end else if (!up_ff && cnt_ff == '0) begin
                        nxt_up = 1'b1;
                        nxt_cnt = cnt_ff + 1'b1;
                        tc = 1'b1;
                    end else begin
                        nxt_cnt = up_ff ? cnt_ff + 1'b1 : cnt_ff - 1'b1;
                    end
                end
            endcase
        end
    end

    assign cmp_hit = count_step && nxt_cnt == cmp_ff;

    // Run and kill state; a halt outranks reload and start
    always_comb begin
        nxt_running = running_ff;
        nxt_kill = kill_ff;
        if (halt_ev) begin
            nxt_running = 1'b0;
            nxt_kill = 1'b1;
        end else if (ev[pwm_pkg::EV_RELOAD] || ev[pwm_pkg::EV_START]) begin
            nxt_running = 1'b1;
            nxt_kill = 1'b0;
        end
    end

    // Period start applies the terminal action, compare match the compare action
    always_comb begin
        nxt_line = line_ff;
        if ((ev[pwm_pkg::EV_RELOAD] && !halt_ev) || tc) begin
            nxt_line = apply_act(tc_act, nxt_line);
        end
        if (cmp_hit) begin
            nxt_line = apply_act(cmp_act, nxt_line);
        end
    end

    // ======================================================
    // Counter state registers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_ff <= '0;
            up_ff <= 1'b1;
            running_ff <= 1'b0;
            kill_ff <= 1'b0;
            line_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            up_ff <= nxt_up;
            running_ff <= nxt_running;
            kill_ff <= nxt_kill;
            line_ff <= nxt_line;
        end
    end

    // Output from a flop, forced low while killed or outside PWM mode
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_line && !nxt_kill && pwm_mode;
        end
    end

    // Pending switch; a new switch event wins over the terminal-count consume
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sw_pend_ff <= 1'b0;
        end else begin
            sw_pend_ff <= ev[pwm_pkg::EV_SWITCH] | (sw_pend_ff & ~tc);
        end
    end

    // ======================================================
    // Register writes; a software write wins over a buffer swap
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_ff <= pwm_pkg::CTRL_RST;
            cmp_ff <= CNT_W'(pwm_pkg::CMP_RST);
            cmp_buf_ff <= '0;
            per_ff <= CNT_W'(pwm_pkg::PER_RST);
            per_buf_ff <= '0;
            dt_ff <= '0;
            sel0_ff <= pwm_pkg::SEL0_RST;
            sel1_ff <= '0;
            edge_ff <= pwm_pkg::EDGE_RST;
            match_ff <= pwm_pkg::MATCH_RST;
        end else begin
            // Switch at terminal count swaps the live and buffered values
            if (tc && sw_pend_ff && ctrl_ff[pwm_pkg::CTRL_SWAP_CMP]) begin
                cmp_ff <= cmp_buf_ff;
                cmp_buf_ff <= cmp_ff;
            end
            if (tc && sw_pend_ff && ctrl_ff[pwm_pkg::CTRL_SWAP_PER]) begin
                per_ff <= per_buf_ff;
                per_buf_ff <= per_ff;
            end
            if (wr_en) begin
                case (addr)
                    pwm_pkg::OFS_CTRL: ctrl_ff <= wr_data;
                    pwm_pkg::OFS_CMP: cmp_ff <= wr_data[CNT_W-1:0];
                    pwm_pkg::OFS_PER: per_ff <= wr_data[CNT_W-1:0];
                    pwm_pkg::OFS_DT: dt_ff <= wr_data;
                    pwm_pkg::OFS_SEL0: sel0_ff <= wr_data;
                    pwm_pkg::OFS_SEL1: sel1_ff <= wr_data;
                    pwm_pkg::OFS_EDGE: edge_ff <= wr_data;
                    pwm_pkg::OFS_MATCH: match_ff <= wr_data;
                    pwm_pkg::OFS_CMP_BUF: cmp_buf_ff <= wr_data[CNT_W-1:0];
                    pwm_pkg::OFS_PER_BUF: per_buf_ff <= wr_data[CNT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ======================================================
    // Register reads; unmapped addresses return zero
    always_comb begin
        case (addr)
            pwm_pkg::OFS_CTRL: nxt_rd = ctrl_ff;
            pwm_pkg::OFS_CMP: nxt_rd = 32'(cmp_ff);
            pwm_pkg::OFS_PER: nxt_rd = 32'(per_ff);
            pwm_pkg::OFS_DT: nxt_rd = dt_ff;
            pwm_pkg::OFS_SEL0: nxt_rd = sel0_ff;
            pwm_pkg::OFS_SEL1: nxt_rd = sel1_ff;
            pwm_pkg::OFS_EDGE: nxt_rd = edge_ff;
            pwm_pkg::OFS_MATCH: nxt_rd = match_ff;
            pwm_pkg::OFS_CMP_BUF: nxt_rd = 32'(cmp_buf_ff);
            pwm_pkg::OFS_PER_BUF: nxt_rd = 32'(per_buf_ff);
            pwm_pkg::OFS_COUNT: nxt_rd = 32'(cnt_ff);
            pwm_pkg::OFS_STATUS: nxt_rd = {27'h0, up_ff, sw_pend_ff, line_ff, kill_ff, running_ff};
            default: nxt_rd = 32'h0000_0000;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_data_ff <= 32'h0000_0000;
        end else begin
            rd_data_ff <= rd_en ? nxt_rd : 32'h0000_0000;
        end
    end

    assign rd_data = rd_data_ff;
    assign high_side_out = out_ff;
    assign counter_running = running_ff;

    // ======================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_cmd(int b);
        wr_en && addr == pwm_pkg::OFS_CMD && wr_data[b];
    endsequence
    sequence s_cmd_live;
        pwm_mode && !halt_ev;
    endsequence

    a_reload_init: assert property (ev[pwm_pkg::EV_RELOAD] && !halt_ev |=> running_ff && cnt_ff == $past(init_val))
        else $error("reload did not load and run");
    a_start_hold: assert property (ev[pwm_pkg::EV_START] && !ev[pwm_pkg::EV_RELOAD] && !halt_ev && !count_step
        |=> running_ff && $stable(cnt_ff))
        else $error("start altered the count");
    a_halt_stop: assert property (ev[pwm_pkg::EV_HALT] |=> !running_ff && !high_side_out)
        else $error("halt left counter or output active");
    a_count_up: assert property (count_step && dir == pwm_pkg::CNT_UP && cnt_ff < per_ff
        |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("up count did not step by one");
    a_count_down: assert property (count_step && dir == pwm_pkg::CNT_DOWN && cnt_ff != '0
        |=> cnt_ff == $past(cnt_ff) - 1'b1)
        else $error("down count did not step by one");
    a_switch_cmd: assert property (s_cmd(pwm_pkg::EV_SWITCH) ##1 pwm_mode |=> sw_pend_ff)
        else $error("switch command lost");
    a_second_halt: assert property (ev[pwm_pkg::EV_HALT2] |=> kill_ff && !running_ff)
        else $error("second halt ignored");
    a_mode_gate: assert property (!pwm_mode |=> !high_side_out)
        else $error("output active outside PWM mode");
    a_sw_reload: assert property (s_cmd(pwm_pkg::EV_RELOAD) ##1 s_cmd_live |=> running_ff && !kill_ff)
        else $error("reload command did not start counter");
    a_sw_kill: assert property (s_cmd(pwm_pkg::EV_HALT) ##1 pwm_mode |=> !high_side_out && !running_ff)
        else $error("halt command did not force output low");
    a_match_clear: assert property (cmp_hit && !tc && cmp_act == pwm_pkg::ACT_CLEAR |=> !line_ff)
        else $error("compare clear not applied");
    a_period_wrap: assert property (count_step && dir == pwm_pkg::CNT_UP && cnt_ff >= per_ff
        |=> cnt_ff == '0)
        else $error("period wrap missed");

    // Start, switch, count gating and the up-down turn
    a_start_run: assert property (ev[pwm_pkg::EV_START] && !halt_ev |=> running_ff && !kill_ff)
        else $error("start did not run counter");
    a_switch_pend: assert property (ev[pwm_pkg::EV_SWITCH] |=> sw_pend_ff)
        else $error("switch event not pending");
    a_count_gate: assert property (!count_step && !ev[pwm_pkg::EV_RELOAD] |=> $stable(cnt_ff))
        else $error("count moved without a step");
    a_updown_turn: assert property (count_step && dir == pwm_pkg::CNT_UPDN1 && up_ff && cnt_ff >= per_ff
        |=> !up_ff)
        else $error("up-down count did not turn");
endmodule : commutation_pwm_counter

// File: design/pwm_pkg.sv
// Package: register map, field layout, reset values and enumerations of the PWM counter
package pwm_pkg;
    // ======================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMP = 8'h04;
    localparam logic [7:0] OFS_PER = 8'h08;
    localparam logic [7:0] OFS_DT = 8'h0C;
    localparam logic [7:0] OFS_SEL0 = 8'h10;
    localparam logic [7:0] OFS_EDGE = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_COUNT = 8'h20;
    localparam logic [7:0] OFS_SEL1 = 8'h24;
    localparam logic [7:0] OFS_MATCH = 8'h28;
    localparam logic [7:0] OFS_CMP_BUF = 8'h2C;
    localparam logic [7:0] OFS_PER_BUF = 8'h30;
    // ======================================================
    // Field positions
    localparam int CTRL_SWAP_CMP = 0;
    localparam int CTRL_SWAP_PER = 1;
    localparam int CTRL_DIR_LSB = 16;
    localparam int CTRL_MODE_LSB = 24;
    localparam int MATCH_CMP_LSB = 0;
    localparam int MATCH_TC_LSB = 2;
    localparam logic [2:0] MODE_PWM = 3'h4;
    // Event index equals its command bit in the software command register
    localparam int EV_SWITCH = 0;
    localparam int EV_COUNT = 1;
    localparam int EV_RELOAD = 2;
    localparam int EV_HALT = 3;
    localparam int EV_START = 4;
    localparam int EV_HALT2 = 5;
    localparam int NUM_EV = 6;
    localparam logic [7:0] SEL_LOW = 8'h00;
    localparam logic [7:0] SEL_HIGH = 8'h01;
    localparam logic [7:0] SEL_FIRST = 8'h02;
    // ======================================================
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0400_0000;
    localparam logic [31:0] CMP_RST = 32'h0000_0040;
    localparam logic [31:0] PER_RST = 32'h0000_00EF;
    localparam logic [31:0] SEL0_RST = 32'h0000_0100;
    localparam logic [31:0] EDGE_RST = 32'h0000_0FFF;
    localparam logic [31:0] MATCH_RST = 32'h0000_0001;
    // ======================================================
    // Enumerations
    typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_ANY = 2'h2, EDGE_NONE = 2'h3} edge_e;
    typedef enum logic [1:0] {ACT_SET = 2'h0, ACT_CLEAR = 2'h1, ACT_INVERT = 2'h2, ACT_KEEP = 2'h3} match_e;
    typedef enum logic [1:0] {CNT_UP = 2'h0, CNT_DOWN = 2'h1, CNT_UPDN1 = 2'h2, CNT_UPDN2 = 2'h3} dir_e;
endpackage : pwm_pkg

// File: design/trig_if.sv
// Interface: trigger selection settings out, detected event pulses back
`timescale 1ns/1ps
interface trig_if;
    logic [pwm_pkg::NUM_EV-1:0][7:0] sel;
    logic [pwm_pkg::NUM_EV-1:0][1:0] edge_mode;
    logic [pwm_pkg::NUM_EV-1:0] ev;
    modport ctrl (output sel, output edge_mode, input ev);
    modport det (input sel, input edge_mode, output ev);
endinterface : trig_if

// File: design/trig_detect.sv
// Trigger synchroniser, source selection and edge detection for every counter event
`timescale 1ns/1ps
module trig_detect #(
    parameter int N_TRIG = 254
) (
    input wire logic clock,              // 200 MHz clock
    input wire logic rst_b,              // Synchronous reset, active low
    input wire logic [N_TRIG-1:0] trig_in, // Asynchronous trigger lines
    trig_if.det tif                      // Settings in, events out
);
    logic [N_TRIG-1:0] sync1_ff;
    logic [N_TRIG-1:0] sync2_ff;
    logic [pwm_pkg::NUM_EV-1:0] lvl;
    logic [pwm_pkg::NUM_EV-1:0] prev_ff;

    // ======================================================
    // Two-stage synchroniser; only the second stage feeds the selectors
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= trig_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ======================================================
    // Per event: pick the source level, then detect the programmed edge
    for (genvar i = 0; i < pwm_pkg::NUM_EV; i++) begin : g_ev
        logic [7:0] idx;
        assign idx = tif.sel[i] - pwm_pkg::SEL_FIRST;
        // Codes 0 and 1 are constant levels, the rest pick an input
        always_comb begin
            if (tif.sel[i] == pwm_pkg::SEL_LOW) begin
                lvl[i] = 1'b0;
            end else if (tif.sel[i] == pwm_pkg::SEL_HIGH) begin
                lvl[i] = 1'b1;
            end else begin
                lvl[i] = (32'(idx) < N_TRIG) ? sync2_ff[idx] : 1'b0;
            end
        end
        always_ff @(posedge clock) begin
            if (!rst_b) begin
                prev_ff[i] <= 1'b0;
            end else begin
                prev_ff[i] <= lvl[i];
            end
        end
        // No-edge code passes the level, giving one event per cycle it is high
        always_comb begin
            case (pwm_pkg::edge_e'(tif.edge_mode[i]))
                pwm_pkg::EDGE_RISE: tif.ev[i] = lvl[i] & ~prev_ff[i];
                pwm_pkg::EDGE_FALL: tif.ev[i] = ~lvl[i] & prev_ff[i];
                pwm_pkg::EDGE_ANY: tif.ev[i] = lvl[i] ^ prev_ff[i];
                default: tif.ev[i] = lvl[i];
            endcase
        end
    end
endmodule : trig_detect

// File: design/prescale_tick.sv
// Count prescaler: one-cycle enable every 2^n clocks
`timescale 1ns/1ps
module prescale_tick (
    input wire logic clock,        // 200 MHz clock
    input wire logic rst_b,        // Synchronous reset, active low
    input wire logic clear,        // Restart division, pulse
    input wire logic [2:0] div_sel, // Divide by 2^div_sel
    output logic tick              // Count enable pulse
);
    logic [7:0] div_ff;
    logic [7:0] mask;

    // Low div_sel bits all ones marks the end of a division period
    assign mask = 8'(8'h01 << div_sel) - 8'h01;
    assign tick = (div_ff & mask) == mask;

    // ======================================================
    // Free-running divider, restarted by a reload
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
endmodule : prescale_tick

// File: verif/gate_driver_model.sv
// Gate driver model: tallies the cycles that the high-side switch is on
`timescale 1ns/1ps
module gate_driver_model (
    input wire logic clock,       // 200 MHz clock
    input wire logic rst_b,       // Synchronous reset, active low
    input wire logic gate_in,     // High-side PWM line
    input wire logic clear,       // Restart the tally
    output logic [15:0] on_cycles // Cycles on since clear
);
    // ======================================================
    // On-time tally
    logic [15:0] on_cnt_ff;
    // An unknown line counts as off, so it can never pass for a drive
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            on_cnt_ff <= 16'h0000;
        end else if (gate_in === 1'b1) begin
            on_cnt_ff <= on_cnt_ff + 16'h0001; // Duty tally
        end
    end
    assign on_cycles = on_cnt_ff;
endmodule : gate_driver_model

// File: verif/test_commutation_pwm_counter.sv
// Testbench: register-level tests of the PWM counter channel
`timescale 1ns/1ps
module test_commutation_pwm_counter;
    // ======================================================
    // Signals and instances
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [253:0] trig_in = '0;
    logic clear = 1'b0;
    logic [31:0] rd_data;
    logic high_side_out;
    logic counter_running;
    logic [15:0] on_cycles;
    logic [31:0] v;
    int err_count = 0;
    int cmp_count = 0;
    commutation_pwm_counter dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .trig_in(trig_in), .high_side_out(high_side_out),
        .counter_running(counter_running));
    gate_driver_model gate (.clock(clock), .rst_b(rst_b), .gate_in(high_side_out), .clear(clear),
        .on_cycles(on_cycles));
    // Free-running 200 MHz clock
    initial begin
        forever #2.5 clock = ~clock;
    end
    // ======================================================
    // Tasks
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task expect_reg(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 check(rd_data, exp, msg);
    endtask : expect_reg
    // Bounded wait on the running flag; running out of time ends the run
    task wait_run(input logic exp);
        for (int i = 0; i < 20 && counter_running !== exp; i++) begin
            @(posedge clock);
            #1;
        end
        check({31'h0, counter_running}, {31'h0, exp}, "running flag");
        if (counter_running !== exp) begin
            close_out();
        end
    endtask : wait_run
    // ======================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        expect_reg(pwm_pkg::OFS_CTRL, pwm_pkg::CTRL_RST, "ctrl"); // Mode field
        expect_reg(pwm_pkg::OFS_CMP, pwm_pkg::CMP_RST, "cmp"); // Compare
        expect_reg(pwm_pkg::OFS_PER, pwm_pkg::PER_RST, "per"); // Period
        expect_reg(pwm_pkg::OFS_SEL0, pwm_pkg::SEL0_RST, "sel0"); // Sources
        expect_reg(pwm_pkg::OFS_EDGE, pwm_pkg::EDGE_RST, "edge"); // Edges
        expect_reg(pwm_pkg::OFS_MATCH, pwm_pkg::MATCH_RST, "match"); // Actions
        expect_reg(8'h3C, 32'h0000_0000, "unmapped");
        $display("reset values test done");
        // Period 16, compare 8: set on terminal, then each compare action
        wr(pwm_pkg::OFS_PER, 32'h0000_000F);
        wr(pwm_pkg::OFS_CMP, 32'h0000_0008);
        for (int k = 0; k < 4; k++) begin
            wr(pwm_pkg::OFS_MATCH, 32'(k));
            wr(pwm_pkg::OFS_CMD, 32'h0000_0004);
            wait_run(1'b1); // Reload command
            repeat (20) @(posedge clock);
            clear <= 1'b1;
            @(posedge clock);
            clear <= 1'b0;
            repeat (32) @(posedge clock);
            #1 check({16'h0, on_cycles}, (k == 0 || k == 3) ? 32'd32 : 32'd16, "on time"); // Duty
            wr(pwm_pkg::OFS_CMD, 32'h0000_0008);
            wait_run(1'b0); // Halt command
            check({31'h0, high_side_out}, 32'h0, "out after halt"); // Output off
        end
        $display("waveform test done");
        // Count source held low: only software count steps
        wr(pwm_pkg::OFS_SEL0, 32'h0000_0000);
        wr(pwm_pkg::OFS_CMD, 32'h0000_0004);
        wait_run(1'b1);
        expect_reg(pwm_pkg::OFS_COUNT, 32'h0, "count after reload"); // Initial value
        wr(pwm_pkg::OFS_CMD, 32'h0000_0002);
        expect_reg(pwm_pkg::OFS_COUNT, 32'h1, "count up"); // Step up
        wr(pwm_pkg::OFS_CMD, 32'h0000_0008);
        wait_run(1'b0);
        wr(pwm_pkg::OFS_CMD, 32'h0000_0002);
        expect_reg(pwm_pkg::OFS_COUNT, 32'h1, "halted count"); // Stopped
        wr(pwm_pkg::OFS_CMD, 32'h0000_0010);
        wait_run(1'b1); // Start runs
        expect_reg(pwm_pkg::OFS_COUNT, 32'h1, "count after start"); // Kept value
        wr(pwm_pkg::OFS_CTRL, pwm_pkg::CTRL_RST | 32'h0001_0000);
        wr(pwm_pkg::OFS_CMD, 32'h0000_0002);
        expect_reg(pwm_pkg::OFS_COUNT, 32'h0, "count down"); // Step down
        // Up-down with a switch: turn at the period, compare swap at zero
        wr(pwm_pkg::OFS_CTRL, pwm_pkg::CTRL_RST | 32'h0002_0001);
        wr(pwm_pkg::OFS_PER, 32'h0000_0002);
        wr(pwm_pkg::OFS_CMP_BUF, 32'h0000_0005);
        wr(pwm_pkg::OFS_CMD, 32'h0000_0005);
        repeat (5) wr(pwm_pkg::OFS_CMD, 32'h0000_0002);
        expect_reg(pwm_pkg::OFS_COUNT, 32'h1, "up-down count"); // Turn at period
        expect_reg(pwm_pkg::OFS_CMP, 32'h5, "switched compare"); // Switch swap
        wr(pwm_pkg::OFS_CMD, 32'h0000_0020);
        wait_run(1'b0); // Second halt
        $display("count test done");
        // Timer mode ignores a reload
        wr(pwm_pkg::OFS_CTRL, 32'h0000_0000);
        wr(pwm_pkg::OFS_CMD, 32'h0000_0004);
        repeat (4) @(posedge clock);
        #1 check({31'h0, counter_running}, 32'h0, "run outside pwm"); // Mode gate
        check({31'h0, high_side_out}, 32'h0, "out outside pwm"); // Mode gate
        wr(pwm_pkg::OFS_CTRL, pwm_pkg::CTRL_RST);
        $display("mode test done");
        // Reload on falling trig_in[0], halt on any edge of trig_in[3]
        wr(pwm_pkg::OFS_SEL0, 32'h0502_0000);
        wr(pwm_pkg::OFS_EDGE, 32'h0000_0F9F);
        trig_in[0] <= 1'b1;
        repeat (8) @(posedge clock);
        #1 check({31'h0, counter_running}, 32'h0, "rising ignored"); // Falling only
        @(posedge clock);
        trig_in[0] <= 1'b0;
        wait_run(1'b1); // Trigger pick
        @(posedge clock);
        trig_in[3] <= 1'b1;
        wait_run(1'b0); // Trigger halt
        @(posedge clock);
        trig_in[0] <= 1'b1;
        repeat (4) @(posedge clock);
        trig_in[0] <= 1'b0;
        wait_run(1'b1); // Falling reload
        @(posedge clock);
        trig_in[3] <= 1'b0;
        wait_run(1'b0); // Falling halt on any-edge code
        $display("trigger test done");
        close_out();
    end
endmodule : test_commutation_pwm_counter
